/* verilog/etd_pkg.sv */
// constants and types shared by the edge, toggle and delay blocks
package etd_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int SCAN_TIME_NS  = 1000000;
  localparam int SCAN_CYCLES   = SCAN_TIME_NS / CLK_PERIOD_NS;
  localparam int BASE_TIME_NS  = 10000000;
  localparam int BASE_CYCLES   = BASE_TIME_NS / CLK_PERIOD_NS;
  localparam int DIV_100MS     = 10;
  localparam int DIV_1S        = 100;
  localparam int LAG_W         = 15;
  localparam logic [14:0] LAG_MAX   = 15'h7FFF;
  localparam logic [14:0] LAG_RESET = 15'h0000;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_ON_SET  = 8'h04;
  localparam logic [7:0] ADDR_OFF_SET = 8'h08;
  localparam logic [7:0] ADDR_ON_EL   = 8'h0C;
  localparam logic [7:0] ADDR_OFF_EL  = 8'h10;
  localparam logic [7:0] ADDR_STATUS  = 8'h14;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_ON_EN    = 2;
  localparam int CTRL_OFF_EN   = 3;
  localparam int CTRL_UNIT_LSB = 4;
  localparam int CTRL_W        = 6;
  localparam logic [5:0] CTRL_RESET = 6'h00;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    RISING_MODE    = 2'h0,
    FALLING_MODE   = 2'h1,
    DUAL_EDGE_MODE = 2'h2
  } etd_edge_t;

  typedef enum logic [1:0] {
    UNIT_10MS  = 2'h0,
    UNIT_100MS = 2'h1,
    UNIT_1S    = 2'h2
  } etd_unit_t;

  typedef enum logic [1:0] {
    DLY_IDLE     = 2'h0,
    DLY_ON_WAIT  = 2'h1,
    DLY_ACTIVE   = 2'h3,
    DLY_OFF_WAIT = 2'h2
  } etd_dly_state_t;

endpackage

/* verilog/etd_delay.sv */
// delay timer with separate turn-on and turn-off lag
`timescale 1ns/10ps
module etd_delay import etd_pkg::*; (
  input  wire logic             i_clk,
  input  wire logic             i_reset,
  input  wire logic             i_ce,
  input  wire logic             i_scan,
  input  wire logic             i_unit,
  input  wire logic             i_src,
  input  wire logic             i_clr,
  input  wire logic             i_on_en,
  input  wire logic             i_off_en,
  input  wire logic [LAG_W-1:0] i_on_set,
  input  wire logic [LAG_W-1:0] i_off_set,
  output logic                  o_out,
  output logic      [LAG_W-1:0] o_on_el,
  output logic      [LAG_W-1:0] o_off_el
);

  etd_dly_state_t   st_q, st_d;
  logic             out_q, out_d;
  logic [LAG_W-1:0] on_q, on_d, off_q, off_d;

  function automatic logic [LAG_W-1:0] sat_inc(input logic [LAG_W-1:0] v);
    sat_inc = (v == LAG_MAX) ? v : v + 15'h0001;
  endfunction

  // elapsed counts run on unit ticks; decisions fall on scan ticks only
  always_comb begin
    st_d  = st_q;
    out_d = out_q;
    on_d  = on_q;
    off_d = off_q;
    if (i_unit) begin
      if (st_q == DLY_ON_WAIT)  on_d  = sat_inc(on_q);
      if (st_q == DLY_OFF_WAIT) off_d = sat_inc(off_q);
    end
    if (i_scan) begin
      if (i_clr) begin
        st_d  = DLY_IDLE;
        out_d = 1'b0;
        on_d  = LAG_RESET;
        off_d = LAG_RESET;
      end else begin
        case (st_q)
          DLY_IDLE: if (i_src) begin
            if (i_on_en && i_on_set != LAG_RESET) begin
              st_d = DLY_ON_WAIT;
              on_d = LAG_RESET;
            end else begin
              st_d  = DLY_ACTIVE;
              out_d = 1'b1;
            end
          end
          DLY_ON_WAIT: if (!i_src) begin
            st_d = DLY_IDLE;
            on_d = LAG_RESET;
          end else if (on_q >= i_on_set) begin
            st_d  = DLY_ACTIVE;
            out_d = 1'b1;
          end
          DLY_ACTIVE: if (!i_src) begin
            if (i_off_en && i_off_set != LAG_RESET) begin
              st_d  = DLY_OFF_WAIT;
              off_d = LAG_RESET;
            end else begin
              st_d  = DLY_IDLE;
              out_d = 1'b0;
            end
          end
          DLY_OFF_WAIT: if (i_src) begin
            st_d  = DLY_ACTIVE;
            off_d = LAG_RESET;
          end else if (!i_off_en || off_q >= i_off_set) begin
            st_d  = DLY_IDLE;
            out_d = 1'b0;
          end
          default: begin
            st_d  = DLY_IDLE;
            out_d = 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      st_q  <= DLY_IDLE;
      out_q <= 1'b0;
      on_q  <= LAG_RESET;
      off_q <= LAG_RESET;
    end else if (i_ce) begin
      st_q  <= st_d;
      out_q <= out_d;
      on_q  <= on_d;
      off_q <= off_d;
    end
  end

  assign o_out    = out_q;
  assign o_on_el  = on_q;
  assign o_off_el = off_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  dly_clear_a: assert property (@(posedge i_clk) disable iff (i_reset)
    i_ce && i_scan && i_clr |=> !out_q && on_q == 15'h0000
      && off_q == 15'h0000)
    else $error("delay clear did not zero counts and output");
  dly_onwait_a: assert property (@(posedge i_clk) disable iff (i_reset)
    $rose(out_q) && $past(st_q) == DLY_ON_WAIT
      |-> $past(on_q) >= $past(i_on_set) && $past(i_src))
    else $error("delay output rose before turn-on lag ran out");
  dly_offhold_a: assert property (@(posedge i_clk) disable iff (i_reset)
    st_q == DLY_OFF_WAIT |-> out_q)
    else $error("delay output dropped during turn-off lag");
  dly_reach_c: cover property (@(posedge i_clk) disable iff (i_reset)
    st_q == DLY_ON_WAIT ##1 st_q == DLY_ACTIVE);
  dly_offend_c: cover property (@(posedge i_clk) disable iff (i_reset)
    st_q == DLY_OFF_WAIT ##1 st_q == DLY_IDLE);

endmodule

/* verilog/etd_top.sv */
// edge pulse generator, toggle and delay timer behind an AXI4-Lite slave
`timescale 1ns/10ps
module etd_top import etd_pkg::*; #(
  parameter int SCAN_CYC = SCAN_CYCLES,
  parameter int BASE_CYC = BASE_CYCLES
) (
  input  wire logic              i_clk,
  input  wire logic              i_reset,
  input  wire logic              i_ce,
  input  wire logic              i_pl_in,
  input  wire logic              i_tg_in,
  input  wire logic              i_tg_clr,
  input  wire logic              i_dl_in,
  input  wire logic              i_dl_clr,
  input  wire logic              i_awvalid,
  input  wire logic [ADDR_W-1:0] i_awaddr,
  input  wire logic              i_wvalid,
  input  wire logic [31:0]       i_wdata,
  input  wire logic [3:0]        i_wstrb,
  input  wire logic              i_bready,
  input  wire logic              i_arvalid,
  input  wire logic [ADDR_W-1:0] i_araddr,
  input  wire logic              i_rready,
  output logic                   o_awready,
  output logic                   o_wready,
  output logic                   o_bvalid,
  output logic      [1:0]        o_bresp,
  output logic                   o_arready,
  output logic                   o_rvalid,
  output logic      [31:0]       o_rdata,
  output logic      [1:0]        o_rresp,
  output logic                   o_pulse,
  output logic                   o_toggle,
  output logic                   o_delay,
  output logic      [LAG_W-1:0]  o_on_lag_set,
  output logic      [LAG_W-1:0]  o_off_lag_set,
  output logic      [LAG_W-1:0]  o_on_lag_el,
  output logic      [LAG_W-1:0]  o_off_lag_el
);

  localparam int SW = $clog2(SCAN_CYC);
  localparam int BW = $clog2(BASE_CYC);

  // ****************************************************************
  // time base
  // ****************************************************************
  logic [SW-1:0] scan_cnt_q, scan_cnt_d;
  logic [BW-1:0] base_cnt_q, base_cnt_d;
  logic [3:0]    dec_cnt_q, dec_cnt_d;
  logic [6:0]    hun_cnt_q, hun_cnt_d;
  logic          scan_q, scan_d;
  logic          unit_q, unit_d;
  logic          t10, t100, t1s;
  logic [CTRL_W-1:0] ctrl_q, ctrl_d;

  always_comb begin
    scan_cnt_d = scan_cnt_q + 1'b1;
    scan_d     = 1'b0;
    if (scan_cnt_q == SW'(SCAN_CYC - 1)) begin
      scan_cnt_d = '0;
      scan_d     = 1'b1;
    end
    base_cnt_d = base_cnt_q + 1'b1;
    dec_cnt_d  = dec_cnt_q;
    hun_cnt_d  = hun_cnt_q;
    t10  = (base_cnt_q == BW'(BASE_CYC - 1));
    t100 = t10 && dec_cnt_q == 4'(DIV_100MS - 1);
    t1s  = t10 && hun_cnt_q == 7'(DIV_1S - 1);
    if (t10) begin
      base_cnt_d = '0;
      dec_cnt_d  = t100 ? 4'h0 : dec_cnt_q + 4'h1;
      hun_cnt_d  = t1s ? 7'h00 : hun_cnt_q + 7'h01;
    end
    case (ctrl_q[CTRL_UNIT_LSB +: 2])
      UNIT_10MS:  unit_d = t10;
      UNIT_100MS: unit_d = t100;
      UNIT_1S:    unit_d = t1s;
      default:    unit_d = t1s;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      scan_cnt_q <= '0;
      base_cnt_q <= '0;
      dec_cnt_q  <= 4'h0;
      hun_cnt_q  <= 7'h00;
      scan_q     <= 1'b0;
      unit_q     <= 1'b0;
    end else if (i_ce) begin
      scan_cnt_q <= scan_cnt_d;
      base_cnt_q <= base_cnt_d;
      dec_cnt_q  <= dec_cnt_d;
      hun_cnt_q  <= hun_cnt_d;
      scan_q     <= scan_d;
      unit_q     <= unit_d;
    end
  end

  // ****************************************************************
  // edge pulse generator and toggle
  // ****************************************************************
  logic pl_prev_q, pl_prev_d;
  logic pulse_q, pulse_d;
  logic tg_prev_q, tg_prev_d;
  logic toggle_q, toggle_d;

  // the code 3 is left unused and makes no pulse at all
  function automatic logic edge_hit(input logic [1:0] mode,
                                    input logic cur, input logic prev);
    case (mode)
      RISING_MODE:    edge_hit = cur && !prev;
      FALLING_MODE:   edge_hit = !cur && prev;
      DUAL_EDGE_MODE: edge_hit = cur != prev;
      default:        edge_hit = 1'b0;
    endcase
  endfunction

  always_comb begin
    pl_prev_d = pl_prev_q;
    pulse_d   = pulse_q;
    tg_prev_d = tg_prev_q;
    toggle_d  = toggle_q;
    if (scan_q) begin
      pulse_d   = edge_hit(ctrl_q[CTRL_MODE_LSB +: 2], i_pl_in,
                           pl_prev_q);
      pl_prev_d = i_pl_in;
      tg_prev_d = i_tg_in;
      if (i_tg_clr) begin
        toggle_d = 1'b0;
      end else if (i_tg_in && !tg_prev_q) begin
        toggle_d = !toggle_q;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      pl_prev_q <= 1'b0;
      pulse_q   <= 1'b0;
      tg_prev_q <= 1'b0;
      toggle_q  <= 1'b0;
    end else if (i_ce) begin
      pl_prev_q <= pl_prev_d;
      pulse_q   <= pulse_d;
      tg_prev_q <= tg_prev_d;
      toggle_q  <= toggle_d;
    end
  end

  // ****************************************************************
  // delay timer
  // ****************************************************************
  logic [LAG_W-1:0] on_set_q, on_set_d, off_set_q, off_set_d;
  logic [LAG_W-1:0] on_el, off_el;
  logic             dly_out;

  etd_delay etd_delay_i (
    .i_clk     (i_clk),
    .i_reset   (i_reset),
    .i_ce      (i_ce),
    .i_scan    (scan_q),
    .i_unit    (unit_q),
    .i_src     (i_dl_in),
    .i_clr     (i_dl_clr),
    .i_on_en   (ctrl_q[CTRL_ON_EN]),
    .i_off_en  (ctrl_q[CTRL_OFF_EN]),
    .i_on_set  (on_set_q),
    .i_off_set (off_set_q),
    .o_out     (dly_out),
    .o_on_el   (on_el),
    .o_off_el  (off_el)
  );

  // ****************************************************************
  // register slave
  // ****************************************************************
  logic              aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [ADDR_W-1:0] awaddr_q, awaddr_d;
  logic [31:0]       wdata_q, wdata_d, wtmp;
  logic [3:0]        wstrb_q, wstrb_d;
  logic              awready_q, awready_d, wready_q, wready_d;
  logic              bvalid_q, bvalid_d, arready_q, arready_d;
  logic              rvalid_q, rvalid_d;
  logic [1:0]        bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0]       rdata_q, rdata_d;

  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0] strb);
    for (int b = 0; b < 4; b++)
      wmerge[8*b +: 8] = strb[b] ? nw[8*b +: 8] : old[8*b +: 8];
  endfunction

  always_comb begin
    aw_have_d = aw_have_q;
    awaddr_d  = awaddr_q;
    w_have_d  = w_have_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    ctrl_d    = ctrl_q;
    on_set_d  = on_set_q;
    off_set_d = off_set_q;
    wtmp      = 32'h0000_0000;
    if (awready_q && i_awvalid) begin
      aw_have_d = 1'b1;
      awaddr_d  = i_awaddr;
    end
    if (wready_q && i_wvalid) begin
      w_have_d = 1'b1;
      wdata_d  = i_wdata;
      wstrb_d  = i_wstrb;
    end
    if (bvalid_q && i_bready) bvalid_d = 1'b0;
    if (aw_have_q && w_have_q && !bvalid_q) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = RESP_OKAY;
      case (awaddr_q)
        ADDR_CTRL: begin
          wtmp   = wmerge({26'h0, ctrl_q}, wdata_q, wstrb_q);
          ctrl_d = wtmp[CTRL_W-1:0];
        end
        ADDR_ON_SET: begin
          wtmp     = wmerge({17'h0, on_set_q}, wdata_q, wstrb_q);
          on_set_d = wtmp[LAG_W-1:0];
        end
        ADDR_OFF_SET: begin
          wtmp      = wmerge({17'h0, off_set_q}, wdata_q, wstrb_q);
          off_set_d = wtmp[LAG_W-1:0];
        end
        ADDR_ON_EL, ADDR_OFF_EL, ADDR_STATUS: bresp_d = RESP_OKAY;
        default: bresp_d = RESP_SLVERR;
      endcase
    end
    if (rvalid_q && i_rready) rvalid_d = 1'b0;
    if (arready_q && i_arvalid) begin
      rvalid_d = 1'b1;
      rresp_d  = RESP_OKAY;
      case (i_araddr)
        ADDR_CTRL:    rdata_d = {26'h0, ctrl_q};
        ADDR_ON_SET:  rdata_d = {17'h0, on_set_q};
        ADDR_OFF_SET: rdata_d = {17'h0, off_set_q};
        ADDR_ON_EL:   rdata_d = {17'h0, on_el};
        ADDR_OFF_EL:  rdata_d = {17'h0, off_el};
        ADDR_STATUS:  rdata_d = {29'h0, dly_out, toggle_q, pulse_q};
        default: begin
          rdata_d = 32'h0000_0000;
          rresp_d = RESP_SLVERR;
        end
      endcase
    end
    awready_d = !aw_have_d && !bvalid_d;
    wready_d  = !w_have_d && !bvalid_d;
    arready_d = !rvalid_d;
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      aw_have_q <= 1'b0;
      awaddr_q  <= 8'h00;
      w_have_q  <= 1'b0;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= RESP_OKAY;
      ctrl_q    <= CTRL_RESET;
      on_set_q  <= LAG_RESET;
      off_set_q <= LAG_RESET;
    end else if (i_ce) begin
      aw_have_q <= aw_have_d;
      awaddr_q  <= awaddr_d;
      w_have_q  <= w_have_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
      ctrl_q    <= ctrl_d;
      on_set_q  <= on_set_d;
      off_set_q <= off_set_d;
    end
  end

  assign o_awready     = awready_q;
  assign o_wready      = wready_q;
  assign o_bvalid      = bvalid_q;
  assign o_bresp       = bresp_q;
  assign o_arready     = arready_q;
  assign o_rvalid      = rvalid_q;
  assign o_rdata       = rdata_q;
  assign o_rresp       = rresp_q;
  assign o_pulse       = pulse_q;
  assign o_toggle      = toggle_q;
  assign o_delay       = dly_out;
  assign o_on_lag_set  = on_set_q;
  assign o_off_lag_set = off_set_q;
  assign o_on_lag_el   = on_el;
  assign o_off_lag_el  = off_el;

  // ****************************************************************
  // checks
  // ****************************************************************
  pulse_rise_a: assert property (@(posedge i_clk) disable iff (i_reset)
    i_ce && scan_q && ctrl_q[1:0] == RISING_MODE && i_pl_in && !pl_prev_q
      |=> pulse_q)
    else $error("rising edge gave no pulse");
  pulse_fall_a: assert property (@(posedge i_clk) disable iff (i_reset)
    i_ce && scan_q && ctrl_q[1:0] == FALLING_MODE && !i_pl_in && pl_prev_q
      |=> pulse_q)
    else $error("falling edge gave no pulse");
  pulse_dual_a: assert property (@(posedge i_clk) disable iff (i_reset)
    i_ce && scan_q && ctrl_q[1:0] == DUAL_EDGE_MODE && i_pl_in != pl_prev_q
      |=> pulse_q)
    else $error("input change gave no pulse in dual edge mode");
  pulse_quiet_a: assert property (@(posedge i_clk) disable iff (i_reset)
    i_ce && scan_q && ctrl_q[1:0] == RISING_MODE && !(i_pl_in && !pl_prev_q)
      |=> !pulse_q)
    else $error("pulse without a selected edge");
  pulse_hold_a: assert property (@(posedge i_clk) disable iff (i_reset)
    !(i_ce && scan_q) |=> $stable(pulse_q) && $stable(toggle_q))
    else $error("output moved between scans");
  toggle_flip_a: assert property (@(posedge i_clk) disable iff (i_reset)
    i_ce && scan_q && !i_tg_clr && i_tg_in && !tg_prev_q
      |=> toggle_q != $past(toggle_q))
    else $error("toggle did not invert");
  toggle_clr_a: assert property (@(posedge i_clk) disable iff (i_reset)
    i_ce && scan_q && i_tg_clr |=> !toggle_q)
    else $error("toggle clear did not force off");
  dly_follow_a: assert property (@(posedge i_clk) disable iff (i_reset)
    i_ce && scan_q && !i_dl_clr && !ctrl_q[CTRL_OFF_EN] && !i_dl_in
      |=> !dly_out)
    else $error("delay output stayed on after input dropped");
  pulse_dual_c: cover property (@(posedge i_clk) disable iff (i_reset)
    ctrl_q[1:0] == DUAL_EDGE_MODE && $rose(pulse_q));
  toggle_flip_c: cover property (@(posedge i_clk) disable iff (i_reset)
    $fell(toggle_q) && !$past(i_tg_clr));
  bus_write_c: cover property (@(posedge i_clk) disable iff (i_reset)
    bvalid_q && bresp_q == RESP_OKAY);

endmodule

/* testbench/etd_fb_model.sv */
// stand-in for the neighbouring function blocks that feed the primitives
`timescale 1ns/10ps
module etd_fb_model (
  input  wire logic       i_clk,
  input  wire logic [4:0] i_req,
  output logic      [4:0] o_lvl
);
  // levels move only just after an edge, like a scanned program's outputs
  always_ff @(posedge i_clk) begin
    o_lvl <= i_req;
  end
endmodule

/* testbench/etd_top_tb.sv */
// self-checking bench for the edge, toggle and delay blocks
`timescale 1ns/10ps
module etd_top_tb;
  import etd_pkg::*;
  localparam int SCN = 8;
  logic        i_clk;
  logic        i_reset;
  logic        i_ce;
  logic        awvalid;
  logic        wvalid;
  logic        bready;
  logic        arvalid;
  logic        rready;
  logic [7:0]  awaddr;
  logic [7:0]  araddr;
  logic [31:0] wdata;
  logic [4:0]  req;
  logic [4:0]  lvl;
  logic        o_awready;
  logic        o_wready;
  logic        o_bvalid;
  logic [1:0]  o_bresp;
  logic        o_arready;
  logic        o_rvalid;
  logic [31:0] o_rdata;
  logic [1:0]  o_rresp;
  logic        o_pulse;
  logic        o_toggle;
  logic        o_delay;
  logic [14:0] o_on_lag_set;
  logic [14:0] o_off_lag_set;
  logic [14:0] o_on_lag_el;
  logic [14:0] o_off_lag_el;
  int          fail_count;
  int          checked;

  etd_fb_model etd_fb_model_i (.i_clk(i_clk), .i_req(req), .o_lvl(lvl));

  etd_top #(.SCAN_CYC(SCN), .BASE_CYC(4)) etd_top_i (
    .i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce), .i_pl_in(lvl[0]),
    .i_tg_in(lvl[1]), .i_tg_clr(lvl[2]), .i_dl_in(lvl[3]),
    .i_dl_clr(lvl[4]), .i_awvalid(awvalid), .i_awaddr(awaddr),
    .i_wvalid(wvalid), .i_wdata(wdata), .i_wstrb(4'hF),
    .i_bready(bready), .i_arvalid(arvalid), .i_araddr(araddr),
    .i_rready(rready), .o_awready(o_awready), .o_wready(o_wready),
    .o_bvalid(o_bvalid), .o_bresp(o_bresp), .o_arready(o_arready),
    .o_rvalid(o_rvalid), .o_rdata(o_rdata), .o_rresp(o_rresp),
    .o_pulse(o_pulse), .o_toggle(o_toggle), .o_delay(o_delay),
    .o_on_lag_set(o_on_lag_set), .o_off_lag_set(o_off_lag_set),
    .o_on_lag_el(o_on_lag_el), .o_off_lag_el(o_off_lag_el));

  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic test_done;
    $display("checked %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    int n;
    @(posedge i_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge i_clk);
      if (awvalid && o_awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && o_wready === 1'b1) wvalid <= 1'b0;
      if (o_bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    if (n == 50) begin
      fail_count++;
      test_done;
    end
    chk(o_bresp, er);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    int n;
    @(posedge i_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge i_clk);
      if (arvalid && o_arready === 1'b1) arvalid <= 1'b0;
      if (o_rvalid === 1'b1) break;
    end
    rready <= 1'b0;
    if (n == 50) begin
      fail_count++;
      test_done;
    end
    chk(o_rdata, ed);
    chk(o_rresp, er);
  endtask

  // levels: [0] pulse in, [1] toggle in, [2] toggle clear,
  // [3] delay in, [4] delay clear
  task automatic set(input logic [4:0] v, input int n);
    @(posedge i_clk);
    req <= v;
    repeat (n) @(posedge i_clk);
  endtask

  task automatic t_regs;
    rd(ADDR_CTRL, 32'h0, RESP_OKAY);
    wr(ADDR_ON_SET, 32'h0000FFFF, RESP_OKAY);
    rd(ADDR_ON_SET, 32'h00007FFF, RESP_OKAY);
    chk(o_on_lag_set, LAG_MAX);
    wr(ADDR_OFF_SET, 32'h00007FFF, RESP_OKAY);
    chk(o_off_lag_set, LAG_MAX);
    rd(ADDR_OFF_SET, 32'h00007FFF, RESP_OKAY);
    wr(ADDR_ON_EL, 32'h00001234, RESP_OKAY);
    rd(ADDR_ON_EL, 32'h0, RESP_OKAY);
    wr(8'h18, 32'h1, RESP_SLVERR);
    rd(8'h18, 32'h0, RESP_SLVERR);
    $display("test regs done");
  endtask

  task automatic t_pulse;
    int c1;
    int c2;
    // code 3 is the unused trigger type and must stay silent
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_CTRL, m, RESP_OKAY);
      set(5'h00, 24);
      c1 = 0;
      c2 = 0;
      set(5'h01, 0);
      repeat (32) @(posedge i_clk) c1 += int'(o_pulse === 1'b1);
      set(5'h00, 0);
      repeat (32) @(posedge i_clk) c2 += int'(o_pulse === 1'b1);
      chk(c1, (m == 0 || m == 2) ? SCN : 0);
      chk(c2, (m == 1 || m == 2) ? SCN : 0);
    end
    $display("test pulse done");
  endtask

  task automatic t_toggle;
    set(5'h02, 24);
    chk(o_toggle, 1'b1);
    rd(ADDR_STATUS, 32'h2, RESP_OKAY);
    set(5'h00, 24);
    chk(o_toggle, 1'b1);
    set(5'h02, 24);
    chk(o_toggle, 1'b0);
    set(5'h00, 24);
    set(5'h02, 24);
    chk(o_toggle, 1'b1);
    set(5'h06, 24);
    chk(o_toggle, 1'b0);
    // with the enable low a fresh rising input must not flip the output
    @(posedge i_clk);
    i_ce <= 1'b0;
    set(5'h00, 24);
    set(5'h02, 24);
    chk(o_toggle, 1'b0);
    i_ce <= 1'b1;
    $display("test toggle done");
  endtask

  task automatic t_delay;
    // five 10 ms units span several scans, so the lag is honoured
    wr(ADDR_ON_SET, 32'h5, RESP_OKAY);
    wr(ADDR_OFF_SET, 32'h5, RESP_OKAY);
    wr(ADDR_CTRL, 32'h4, RESP_OKAY);
    set(5'h08, 12);
    chk(o_delay, 1'b0);
    repeat (48) @(posedge i_clk);
    chk(o_delay, 1'b1);
    set(5'h00, 10);
    chk(o_delay, 1'b0);
    wr(ADDR_CTRL, 32'hC, RESP_OKAY);
    set(5'h08, 60);
    chk(o_delay, 1'b1);
    set(5'h00, 12);
    chk(o_delay, 1'b1);
    repeat (48) @(posedge i_clk);
    chk(o_delay, 1'b0);
    set(5'h08, 60);
    set(5'h18, 12);
    chk(o_delay, 1'b0);
    chk(o_on_lag_el, 15'h0);
    chk(o_off_lag_el, 15'h0);
    set(5'h00, 60);
    set(5'h08, 12);
    set(5'h18, 12);
    set(5'h08, 12);
    chk(o_delay, 1'b0);
    wr(ADDR_CTRL, 32'h14, RESP_OKAY);
    wr(ADDR_ON_SET, 32'h2, RESP_OKAY);
    set(5'h00, 24);
    set(5'h08, 24);
    chk(o_delay, 1'b0);
    repeat (80) @(posedge i_clk);
    chk(o_delay, 1'b1);
    // one second units: two ticks need at least 400 clocks
    wr(ADDR_CTRL, 32'h24, RESP_OKAY);
    set(5'h00, 24);
    set(5'h08, 200);
    chk(o_delay, 1'b0);
    repeat (640) @(posedge i_clk);
    chk(o_delay, 1'b1);
    $display("test delay done");
  endtask

  initial begin
    fail_count = 0;
    checked = 0;
    i_reset = 1'b1;
    i_ce = 1'b1;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    req = 5'h00;
    repeat (20) @(posedge i_clk);
    i_reset <= 1'b0;
    t_regs;
    t_pulse;
    t_toggle;
    t_delay;
    test_done;
  end
endmodule
